// [shared/cc_pkg.sv]
// Purpose: Constants and types of the coupler configuration register map
// Assumes: Register numbers are 16-bit word addresses of the serial fieldbus
// Notes:   Summary of operation follows
// Summary of operation
// - Erase allowed only when enabled, idle, supported
// - Zero after arming starts non-volatile erase
// - No zero in 30s: timeout, clear command
// - Erase success: not-configured, defaults, errors cleared
// - Incompatible setup: flag zero, refuse apply, log
// - Incompatible: legacy, counter module, over ten safety
// - Module configuration writes stored without checks
// - Record first ten validation errors, then stop
// - Empty error registers read all ones
// - Unused analog channel: defaults, no error
// - Digital level one: level-two defaults, no error
// - Registers 1-99 mirror first input entries
// - Registers 101-199 mirror first output entries
// - Data areas error unless system state four
// - Data valid only while bus status zero
// - Status and full input areas read-only
// - Full output and configuration areas writable
// - Read-only HMI copy of input and output
// - Direct configuration range accepts controller writes
package cc_pkg;
   // ***********************************************************
   // Register numbers
   // ***********************************************************
   localparam logic [15:0] A_IN_ZERO    = 16'h0000;
   localparam logic [15:0] A_MIR_IN_LO  = 16'h0001;
   localparam logic [15:0] A_MIR_IN_HI  = 16'h0063;
   localparam logic [15:0] A_OUT_ZERO   = 16'h0064;
   localparam logic [15:0] A_MIR_OUT_LO = 16'h0065;
   localparam logic [15:0] A_MIR_OUT_HI = 16'h00c7;
   localparam logic [15:0] A_DIAG       = 16'h0384;
   localparam logic [15:0] A_MOD_ERR    = 16'h0385;
   localparam logic [15:0] A_MOD_STAT   = 16'h03a2;
   localparam logic [15:0] A_BUS_STAT   = 16'h03a3;
   localparam logic [15:0] A_SYS_STATE  = 16'h03a4;
   localparam logic [15:0] A_STAT_LO    = 16'h09c4;
   localparam logic [15:0] A_STAT_HI    = 16'h0bb7;
   localparam logic [15:0] A_FIN_ZERO   = 16'h0bb8;
   localparam logic [15:0] A_FIN_LO     = 16'h0bb9;
   localparam logic [15:0] A_FIN_HI     = 16'h0dab;
   localparam logic [15:0] A_FOUT_ZERO  = 16'h0dac;
   localparam logic [15:0] A_FOUT_LO    = 16'h0dad;
   localparam logic [15:0] A_FOUT_HI    = 16'h0f9f;
   localparam logic [15:0] A_CFG_LO     = 16'h0fa0;
   localparam logic [15:0] A_CFG_HI     = 16'h1b57;
   localparam logic [15:0] A_HIN_ZERO   = 16'h32c8;
   localparam logic [15:0] A_HIN_LO     = 16'h32c9;
   localparam logic [15:0] A_HIN_HI     = 16'h34bb;
   localparam logic [15:0] A_HOUT_ZERO  = 16'h34bc;
   localparam logic [15:0] A_HOUT_LO    = 16'h34bd;
   localparam logic [15:0] A_HOUT_HI    = 16'h36af;
   localparam logic [15:0] A_DIR_LO     = 16'h3a98;
   localparam logic [15:0] A_ERASE      = 16'h3a9a;
   localparam logic [15:0] A_COMPAT     = 16'h3aca;
   localparam logic [15:0] A_ERR_LO     = 16'h3ad5;
   localparam logic [15:0] A_ERR_HI     = 16'h3ae8;
   localparam logic [15:0] A_DIR_HI     = 16'h4073;
   // ***********************************************************
   // Sizes, values and timing
   // ***********************************************************
   localparam int          IO_WORDS     = 499;
   localparam int          CFG_WORDS    = 3000;
   localparam int          DIR_WORDS    = 1500;
   localparam int          ERR_WORDS    = 20;
   localparam logic [3:0]  ERR_MAX      = 4'ha;
   localparam logic [4:0]  SAFETY_MAX   = 5'h0a;
   localparam logic [15:0] ERASE_ARM    = 16'h00ff;
   localparam logic [15:0] ERR_RST      = 16'hffff;
   localparam logic [15:0] SYS_RUN      = 16'h0004;
   localparam logic [15:0] SYS_NOT_CFG  = 16'h0000;
   localparam logic [15:0] SYS_CFGING   = 16'h0001;
   localparam logic [15:0] BUS_OK       = 16'h0000;
   localparam logic [63:0] CLK_HZ       = 64'd250_000_000;
   localparam logic [63:0] ERASE_TO_S   = 64'd30;
   localparam logic [63:0] ERASE_TO_CYC = ERASE_TO_S * CLK_HZ;
   // Erase sequence states
   typedef enum logic [2:0]
   {
      ER_IDLE  = 3'b001,
      ER_ARMED = 3'b010,
      ER_BUSY  = 3'b100
   } cc_erase_t;
endpackage

// [design/cc_regmap.sv]
// Purpose: Register map and configuration management of the fieldbus coupler
// Assumes: One request per i_req pulse, answered on o_ack the next cycle
// Notes:   All status inputs come from logic on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module cc_regmap
   import cc_pkg::*;
#(
   parameter logic [32:0] P_ERASE_TO_CYC = ERASE_TO_CYC[32:0]
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_req,
   input  wire logic        i_wr,
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   output logic             o_ack,
   output logic             o_exc,
   output logic      [15:0] o_rdata,
   input  wire logic        i_cfg_en,
   input  wire logic        i_mods_cfgable,
   input  wire logic        i_web_ctrl,
   input  wire logic        i_fw_update,
   input  wire logic        i_state_wr,
   input  wire logic [15:0] i_state,
   input  wire logic [15:0] i_diag,
   input  wire logic [15:0] i_mod_err,
   input  wire logic [15:0] i_mod_stat,
   input  wire logic [15:0] i_bus_stat,
   output logic             o_nvm_erase,
   input  wire logic        i_nvm_done,
   input  wire logic        i_nvm_ok,
   output logic             o_load_dflt,
   input  wire logic        i_legacy_mod,
   input  wire logic        i_hsc_mod,
   input  wire logic  [4:0] i_safety_cnt,
   input  wire logic        i_apply_req,
   output logic             o_apply,
   output logic             o_log_incompat,
   input  wire logic        i_val_start,
   input  wire logic        i_val_chk,
   input  wire logic        i_val_bad,
   input  wire logic        i_val_unused,
   input  wire logic        i_val_lvl1,
   input  wire logic [15:0] i_val_code,
   input  wire logic  [7:0] i_val_mod,
   input  wire logic  [7:0] i_val_ch,
   output logic             o_use_dflt,
   output logic             o_log_err,
   output logic             o_val_stop,
   input  wire logic        i_in_we,
   input  wire logic  [8:0] i_in_idx,
   input  wire logic [15:0] i_in_data,
   input  wire logic  [8:0] i_out_idx,
   output logic      [15:0] o_out_data
);
   // ***********************************************************
   // Storage and state
   // ***********************************************************
   logic [15:0] in_mem [IO_WORDS];
   logic [15:0] out_mem [IO_WORDS];
   logic [15:0] cfg_mem [CFG_WORDS];
   logic [15:0] dir_mem [DIR_WORDS];
   logic [15:0] err_q [ERR_WORDS];
   cc_erase_t   er_state_ff;
   logic [32:0] er_tmr_ff;
   logic [15:0] erase_cmd_ff;
   logic [15:0] state_ff;
   logic        incompat_ff;
   logic  [3:0] err_cnt_ff;
   logic [15:0] nxt_rd;
   logic        nxt_exc;
   logic        dz;
   logic        ro;
   logic        ow_hit;
   logic        cw_hit;
   logic        dw_hit;
   logic        ew_hit;
   logic [15:0] off;
   logic        wr_ok;
   logic        erase_ok;
   logic        arm_req;
   logic        fire_req;
   logic        tmo;
   logic        done_ok;
   logic        err_clr;
   logic        rec;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   // Erase permitted only in a quiet, enabled setup
   assign erase_ok = i_cfg_en & i_mods_cfgable & ~i_web_ctrl & ~i_fw_update
                     & (state_ff != SYS_CFGING);

   // ***********************************************************
   // Address decode
   // ***********************************************************
   // Zone select, read data and refusal for the current request
   always_comb
   begin
      nxt_rd = 16'h0000;
      nxt_exc = 1'b0;
      dz = 1'b0;
      ro = 1'b0;
      ow_hit = 1'b0;
      cw_hit = 1'b0;
      dw_hit = 1'b0;
      ew_hit = 1'b0;
      off = 16'h0000;
      if (i_addr >= A_MIR_IN_LO && i_addr <= A_MIR_IN_HI)
      begin
         dz = 1'b1; ro = 1'b1; off = i_addr - A_MIR_IN_LO;
         nxt_rd = in_mem[off[8:0]];
      end
      else if (i_addr >= A_MIR_OUT_LO && i_addr <= A_MIR_OUT_HI)
      begin
         dz = 1'b1; ow_hit = 1'b1; off = i_addr - A_MIR_OUT_LO;
         nxt_rd = out_mem[off[8:0]];
      end
      else if (i_addr >= A_FIN_LO && i_addr <= A_FIN_HI)
      begin
         dz = 1'b1; ro = 1'b1; off = i_addr - A_FIN_LO;
         nxt_rd = in_mem[off[8:0]];
      end
      else if (i_addr >= A_FOUT_LO && i_addr <= A_FOUT_HI)
      begin
         dz = 1'b1; ow_hit = 1'b1; off = i_addr - A_FOUT_LO;
         nxt_rd = out_mem[off[8:0]];
      end
      else if (i_addr >= A_HIN_LO && i_addr <= A_HIN_HI)
      begin
         dz = 1'b1; ro = 1'b1; off = i_addr - A_HIN_LO;
         nxt_rd = in_mem[off[8:0]];
      end
      else if (i_addr >= A_HOUT_LO && i_addr <= A_HOUT_HI)
      begin
         dz = 1'b1; ro = 1'b1; off = i_addr - A_HOUT_LO;
         nxt_rd = out_mem[off[8:0]];
      end
      else if (i_addr == A_IN_ZERO || i_addr == A_OUT_ZERO || i_addr == A_FIN_ZERO
               || i_addr == A_FOUT_ZERO || i_addr == A_HIN_ZERO || i_addr == A_HOUT_ZERO)
      begin
         dz = 1'b1; ro = 1'b1; // Unused words read zero
      end
      else if (i_addr >= A_STAT_LO && i_addr <= A_STAT_HI)
         ro = 1'b1;
      else if (i_addr == A_DIAG)
      begin
         ro = 1'b1; nxt_rd = i_diag;
      end
      else if (i_addr == A_MOD_ERR)
      begin
         ro = 1'b1; nxt_rd = i_mod_err;
      end
      else if (i_addr == A_MOD_STAT)
      begin
         ro = 1'b1; nxt_rd = i_mod_stat;
      end
      else if (i_addr == A_BUS_STAT)
      begin
         ro = 1'b1; nxt_rd = i_bus_stat;
      end
      else if (i_addr == A_SYS_STATE)
      begin
         ro = 1'b1; nxt_rd = state_ff;
      end
      else if (i_addr >= A_CFG_LO && i_addr <= A_CFG_HI)
      begin
         cw_hit = 1'b1; off = i_addr - A_CFG_LO;
         nxt_rd = cfg_mem[off[11:0]];
      end
      else if (i_addr == A_ERASE)
      begin
         ew_hit = 1'b1; nxt_rd = erase_cmd_ff;
      end
      else if (i_addr == A_COMPAT)
      begin
         ro = 1'b1; nxt_rd = {15'h0000, ~incompat_ff};
      end
      else if (i_addr >= A_ERR_LO && i_addr <= A_ERR_HI)
      begin
         ro = 1'b1; off = i_addr - A_ERR_LO;
         nxt_rd = err_q[off[4:0]];
      end
      else if (i_addr >= A_DIR_LO && i_addr <= A_DIR_HI)
      begin
         dw_hit = 1'b1; off = i_addr - A_DIR_LO;
         nxt_rd = dir_mem[off[10:0]];
      end
      else
         nxt_exc = 1'b1; // Unmapped register
      if (dz && (state_ff != SYS_RUN || i_bus_stat != BUS_OK))
         nxt_exc = 1'b1;
      if (i_wr && ro)
         nxt_exc = 1'b1;
      if (i_wr && ew_hit)
      begin
         if (i_wdata == ERASE_ARM)
            nxt_exc = ~(erase_ok && er_state_ff == ER_IDLE);
         else if (i_wdata == 16'h0000)
            nxt_exc = (er_state_ff == ER_BUSY);
         else
            nxt_exc = 1'b1;
      end
   end

   assign wr_ok    = i_req & i_wr & ~nxt_exc;
   assign arm_req  = wr_ok & ew_hit & (i_wdata == ERASE_ARM);
   assign fire_req = wr_ok & ew_hit & (i_wdata == 16'h0000) & (er_state_ff == ER_ARMED);
   assign tmo      = (er_state_ff == ER_ARMED) & (er_tmr_ff == P_ERASE_TO_CYC - 33'h1);
   assign done_ok  = (er_state_ff == ER_BUSY) & i_nvm_done & i_nvm_ok;

   // Bus answer, one cycle after the request
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         o_ack <= 1'b0;
         o_exc <= 1'b0;
         o_rdata <= 16'h0000;
      end
      else
      begin
         o_ack <= i_req;
         o_exc <= i_req & nxt_exc;
         o_rdata <= (i_req && !i_wr && !nxt_exc) ? nxt_rd : 16'h0000;
      end
   end

   // Data stores; configuration kept unchecked until applied
   always_ff @(posedge i_sys_clk)
   begin
      if (i_in_we)
         in_mem[i_in_idx] <= i_in_data;
      if (wr_ok && ow_hit)
         out_mem[off[8:0]] <= i_wdata;
      if (wr_ok && cw_hit)
         cfg_mem[off[11:0]] <= i_wdata;
      if (wr_ok && dw_hit)
         dir_mem[off[10:0]] <= i_wdata;
      o_out_data <= out_mem[i_out_idx];
   end

   // ***********************************************************
   // Erase sequence
   // ***********************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         er_state_ff <= ER_IDLE;
         er_tmr_ff <= 33'h0;
         erase_cmd_ff <= 16'h0000;
         o_nvm_erase <= 1'b0;
      end
      else
      begin
         o_nvm_erase <= fire_req;
         unique case (er_state_ff)
            ER_IDLE:
            begin
               er_tmr_ff <= 33'h0;
               if (arm_req)
               begin
                  er_state_ff <= ER_ARMED;
                  erase_cmd_ff <= ERASE_ARM;
               end
               else if (wr_ok && ew_hit)
                  erase_cmd_ff <= 16'h0000;
            end
            ER_ARMED:
            begin
               er_tmr_ff <= er_tmr_ff + 33'h1;
               if (fire_req)
               begin
                  er_state_ff <= ER_BUSY;
                  erase_cmd_ff <= 16'h0000;
               end
               else if (tmo)
               begin
                  er_state_ff <= ER_IDLE;
                  erase_cmd_ff <= 16'h0000;
               end
            end
            ER_BUSY:
            begin
               if (i_nvm_done)
                  er_state_ff <= ER_IDLE;
            end
         endcase
      end
   end

   sequence s_zero;
      i_req && i_wr && i_addr == A_ERASE && i_wdata == 16'h0000;
   endsequence
   sequence s_erase_started;
      o_nvm_erase && er_state_ff == ER_BUSY && erase_cmd_ff == 16'h0000;
   endsequence
   property p_erase_gate;
      (i_req && i_wr && i_addr == A_ERASE && i_wdata == ERASE_ARM && !erase_ok
       && er_state_ff == ER_IDLE) |=> o_ack && o_exc && er_state_ff != ER_ARMED;
   endproperty
   a_erase_gate: assert property (p_erase_gate) else $error("Erase armed while barred");
   property p_erase_fire;
      (er_state_ff == ER_ARMED) ##0 s_zero |=> s_erase_started;
   endproperty
   a_erase_fire: assert property (p_erase_fire) else $error("Erase not started");
   property p_erase_tmo;
      (er_state_ff == ER_ARMED && er_tmr_ff == P_ERASE_TO_CYC - 33'h1 && !i_req)
         |=> er_state_ff == ER_IDLE && erase_cmd_ff == 16'h0000 && !o_nvm_erase;
   endproperty
   a_erase_tmo: assert property (p_erase_tmo) else $error("Erase timeout missed");

   // ***********************************************************
   // System state, defaults and setup check
   // ***********************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         state_ff <= SYS_NOT_CFG;
         o_load_dflt <= 1'b0;
      end
      else
      begin
         o_load_dflt <= done_ok;
         if (done_ok)
            state_ff <= SYS_NOT_CFG;
         else if (i_state_wr)
            state_ff <= i_state;
      end
   end

   property p_erase_done;
      done_ok |=> state_ff == SYS_NOT_CFG && o_load_dflt && err_cnt_ff == 4'h0
                  && err_q[0] == ERR_RST;
   endproperty
   a_erase_done: assert property (p_erase_done) else $error("Erase result wrong");

   // Incompatible setup detection and apply gating
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         incompat_ff <= 1'b0;
         o_apply <= 1'b0;
         o_log_incompat <= 1'b0;
      end
      else
      begin
         incompat_ff <= i_legacy_mod | i_hsc_mod | (i_safety_cnt > SAFETY_MAX);
         o_apply <= i_apply_req & ~incompat_ff;
         o_log_incompat <= i_apply_req & incompat_ff;
      end
   end

   property p_incompat;
      (i_hsc_mod || i_legacy_mod || i_safety_cnt > SAFETY_MAX) ##1 i_apply_req
         |=> !o_apply && o_log_incompat;
   endproperty
   a_incompat: assert property (p_incompat) else $error("Incompatible applied");

   // ***********************************************************
   // Validation error record
   // ***********************************************************
   assign err_clr = done_ok | i_val_start;
   assign rec = i_val_chk & i_val_bad & ~i_val_unused & ~i_val_lvl1
                & (err_cnt_ff < ERR_MAX);

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || err_clr)
      begin
         err_cnt_ff <= 4'h0;
         o_val_stop <= 1'b0;
         o_log_err <= 1'b0;
         o_use_dflt <= 1'b0;
      end
      else
      begin
         if (rec)
            err_cnt_ff <= err_cnt_ff + 4'h1;
         o_val_stop <= (err_cnt_ff == ERR_MAX) || (rec && err_cnt_ff == ERR_MAX - 4'h1);
         o_log_err <= rec;
         o_use_dflt <= i_val_chk & (i_val_unused | i_val_lvl1);
      end
   end

   // Each error takes a code word then a module and channel word
   generate
      for (genvar g = 0; g < ERR_WORDS; g++)
      begin : g_err
         localparam logic [3:0] SLOT = 4'(g / 2);
         always_ff @(posedge i_sys_clk)
         begin
            if (!i_rstn || err_clr)
               err_q[g] <= ERR_RST;
            else if (rec && err_cnt_ff == SLOT)
               err_q[g] <= (g % 2 == 0) ? i_val_code : {i_val_mod, i_val_ch};
         end
      end
   endgenerate

   property p_err_cap;
      (err_cnt_ff == ERR_MAX && !err_clr) |=> err_cnt_ff == ERR_MAX && !o_log_err && o_val_stop;
   endproperty
   a_err_cap: assert property (p_err_cap) else $error("Validation did not stop");
   property p_no_err_dflt;
      (i_val_chk && (i_val_unused || i_val_lvl1) && !err_clr)
         |=> o_use_dflt && !o_log_err && $stable(err_cnt_ff);
   endproperty
   a_no_err_dflt: assert property (p_no_err_dflt) else $error("Default errored");

   // ***********************************************************
   // Access checks
   // ***********************************************************
   property p_data_gate;
      (i_req && dz && state_ff != SYS_RUN) |=> o_ack && o_exc && o_rdata == 16'h0000;
   endproperty
   a_data_gate: assert property (p_data_gate) else $error("Data area open out of run");
   property p_ro_write;
      (i_req && i_wr && ro) |=> o_ack && o_exc && o_rdata == 16'h0000;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("Read-only write accepted");
endmodule // cc_regmap
`default_nettype wire

// [verification/cc_master_model.sv]
// Purpose: Behavioural serial-line master for the register request port
// Assumes: One request in flight; answer one cycle after the strobe
// Notes:   Released address and data lines carry inverted values; o_wr keeps its last one
`timescale 1ns/1ps
`default_nettype none
module cc_master_model
   import cc_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_ack,
   input  wire logic        i_exc,
   input  wire logic [15:0] i_rdata,
   output logic             o_req,
   output logic             o_wr,
   output logic      [15:0] o_addr,
   output logic      [15:0] o_wdata
);
   logic        got_exc;
   logic [15:0] got_data;
   // Idle bus at time zero
   initial
   begin
      o_req   = 1'b0;
      o_wr    = 1'b0;
      o_addr  = 16'hffff;
      o_wdata = 16'h0000;
   end
   // One access: strobe for one cycle, then collect the answer
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] dat);
      int n;
      @(posedge i_sys_clk);
      o_req   <= 1'b1;
      o_wr    <= w;
      o_addr  <= a;
      o_wdata <= dat;
      @(posedge i_sys_clk);
      o_req   <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~dat;
      n = 0;
      do
      begin
         @(posedge i_sys_clk);
         n++;
      end
      while (i_ack !== 1'b1 && n < 4);
      got_exc  = (i_ack === 1'b1) ? i_exc : 1'bx;
      got_data = i_rdata;
   endtask
   // Arming write, then the zero write well inside the window
   task automatic erase_seq(input int gap);
      access(1'b1, A_ERASE, ERASE_ARM);
      repeat (gap) @(posedge i_sys_clk);
      access(1'b1, A_ERASE, 16'h0000);
   endtask
endmodule // cc_master_model
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the coupler register map
// Assumes: Master model issues one request at a time
// Notes:   Expected values come from counters and queues kept here
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cc_pkg::*;
   localparam int TO = 50;
   // Read-only registers probed with writes
   localparam logic [15:0] RO_A [5] = '{A_DIAG, A_FIN_LO, A_HIN_LO, A_STAT_LO, A_SYS_STATE};
   logic        clk, rstn, req, wr, ack, exc, nvm_erase, load_dflt, apply_g, incomp;
   logic        cfg_en, mods, web, fw, st_wr, done, ok, leg, hsc, apply, vs, vc, vb, vu, vl;
   logic        iwe, use_dflt, log_err, val_stop;
   logic [4:0]  safety;
   logic [7:0]  vmod, vch;
   logic [8:0]  in_idx, out_idx;
   logic [15:0] addr, wdata, rdata, state, diag, merr, mstat, bstat, vcode, in_data;
   logic [15:0] out_data, n_erase, n_dflt, n_apply, n_inc, n_use, n_log, d, d2;
   logic [31:0] seed;
   logic [15:0] eq[$];
   int          errors, checked, k;
   cc_master_model cc_master_model_i (.i_sys_clk(clk), .i_ack(ack), .i_exc(exc),
      .i_rdata(rdata), .o_req(req), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
   cc_regmap #(.P_ERASE_TO_CYC(33'(TO))) cc_regmap_i (.i_sys_clk(clk), .i_rstn(rstn),
      .i_req(req), .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_exc(exc),
      .o_rdata(rdata), .i_cfg_en(cfg_en), .i_mods_cfgable(mods), .i_web_ctrl(web),
      .i_fw_update(fw), .i_state_wr(st_wr), .i_state(state), .i_diag(diag),
      .i_mod_err(merr), .i_mod_stat(mstat), .i_bus_stat(bstat), .o_nvm_erase(nvm_erase),
      .i_nvm_done(done), .i_nvm_ok(ok), .o_load_dflt(load_dflt), .i_legacy_mod(leg),
      .i_hsc_mod(hsc), .i_safety_cnt(safety), .i_apply_req(apply), .o_apply(apply_g),
      .o_log_incompat(incomp), .i_val_start(vs), .i_val_chk(vc), .i_val_bad(vb),
      .i_val_unused(vu), .i_val_lvl1(vl), .i_val_code(vcode), .i_val_mod(vmod),
      .i_val_ch(vch), .o_use_dflt(use_dflt), .o_log_err(log_err), .o_val_stop(val_stop),
      .i_in_we(iwe), .i_in_idx(in_idx), .i_in_data(in_data), .i_out_idx(out_idx),
      .o_out_data(out_data));
   // Clock at 250 MHz
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Count one-cycle result pulses
   always @(posedge clk)
   begin
      n_erase <= n_erase + {15'h0, nvm_erase === 1'b1};
      n_dflt  <= n_dflt + {15'h0, load_dflt === 1'b1};
      n_apply <= n_apply + {15'h0, apply_g === 1'b1};
      n_inc   <= n_inc + {15'h0, incomp === 1'b1};
      n_use   <= n_use + {15'h0, use_dflt === 1'b1};
      n_log   <= n_log + {15'h0, log_err === 1'b1};
   end
   // Xorshift source
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   // Compare and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Register read and write through the master model
   task automatic rd(input logic [15:0] a, input logic x, input logic [15:0] v);
      cc_master_model_i.access(1'b0, a, 16'h0000);
      check({15'h0, cc_master_model_i.got_exc}, {15'h0, x});
      check(cc_master_model_i.got_data, x ? 16'h0000 : v);
   endtask
   task automatic wrt(input logic [15:0] a, input logic [15:0] v, input logic x);
      cc_master_model_i.access(1'b1, a, v);
      check({15'h0, cc_master_model_i.got_exc}, {15'h0, x});
   endtask
   task automatic set_state(input logic [15:0] v);
      @(posedge clk);
      st_wr <= 1'b1;
      state <= v;
      @(posedge clk);
      st_wr <= 1'b0;
   endtask
   // One validation step with random error details
   task automatic chk(input logic bad, input logic un, input logic l1);
      @(posedge clk);
      {vc, vb, vu, vl} <= {1'b1, bad, un, l1};
      vcode <= rnd();
      {vmod, vch} <= rnd();
      @(posedge clk);
      vc <= 1'b0;
      if (bad && !un && !l1 && eq.size() < 20)
      begin
         eq.push_back(vcode);
         eq.push_back({vmod, vch});
      end
   endtask
   // Verdict
   task automatic conclude();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
   // Main sequence
   initial
   begin
      {rstn, st_wr, done, ok, leg, hsc, apply, vs, vc, vb, vu, vl, iwe} = '0;
      {cfg_en, mods, web, fw} = 4'b1100;
      {n_erase, n_dflt, n_apply, n_inc, n_use, n_log} = '0;
      {state, bstat, vcode, vmod, vch, in_idx, out_idx, in_data} = '0;
      safety = 5'h00;
      errors = 0;
      checked = 0;
      seed = 32'h0000c2b3;
      {diag, merr, mstat} = {rnd(), rnd(), rnd()};
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd(A_ERASE, 1'b0, 16'h0000);
      rd(A_ERR_LO, 1'b0, ERR_RST);
      rd(A_SYS_STATE, 1'b0, SYS_NOT_CFG);
      rd(A_DIAG, 1'b0, diag);
      for (k = 0; k < 4; k++)
      begin
         @(posedge clk);
         {cfg_en, mods, web, fw} <= 4'b1100 ^ (4'b1000 >> k);
         wrt(A_ERASE, ERASE_ARM, 1'b1);
      end
      {cfg_en, mods, web, fw} <= 4'b1100;
      set_state(SYS_CFGING);
      wrt(A_ERASE, ERASE_ARM, 1'b1);
      set_state(SYS_NOT_CFG);
      wrt(A_ERASE, 16'h0001, 1'b1);
      wrt(A_ERASE, ERASE_ARM, 1'b0);
      rd(A_ERASE, 1'b0, ERASE_ARM);
      repeat (TO + 4) @(posedge clk);
      rd(A_ERASE, 1'b0, 16'h0000);
      check(n_erase, 16'h0000);
      for (k = 0; k < 4; k++)
      begin
         leg <= (k == 0);
         hsc <= (k == 1);
         safety <= (k == 2) ? 5'h0b : 5'h0a;
         repeat (2) @(posedge clk);
         rd(A_COMPAT, 1'b0, {15'h0, k == 3});
         apply <= 1'b1;
         @(posedge clk);
         apply <= 1'b0;
         repeat (2) @(posedge clk);
         check(n_apply, {15'h0, k == 3});
         check(n_inc, (k < 3) ? 16'(k + 1) : 16'h0003);
      end
      rd(A_FIN_LO, 1'b1, 16'h0000);
      set_state(SYS_RUN);
      d = rnd();
      d2 = rnd();
      iwe <= 1'b1;
      in_data <= d;
      @(posedge clk);
      iwe <= 1'b0;
      rd(A_MIR_IN_LO, 1'b0, d);
      rd(A_FIN_LO, 1'b0, d);
      rd(A_HIN_LO, 1'b0, d);
      wrt(A_FOUT_LO, d2, 1'b0);
      rd(A_MIR_OUT_LO, 1'b0, d2);
      rd(A_HOUT_LO, 1'b0, d2);
      check(out_data, d2);
      wrt(A_CFG_LO, ~d, 1'b0);
      rd(A_CFG_LO, 1'b0, ~d);
      for (k = 0; k < 5; k++)
         wrt(RO_A[k], d2, 1'b1);
      rd(A_FIN_LO, 1'b0, d);
      bstat <= 16'h0001;
      rd(A_MIR_IN_LO, 1'b1, 16'h0000);
      bstat <= 16'h0000;
      vs <= 1'b1;
      @(posedge clk);
      vs <= 1'b0;
      chk(1'b1, 1'b1, 1'b0);
      chk(1'b1, 1'b0, 1'b1);
      // Let the last result pulse reach the counters
      repeat (2) @(posedge clk);
      check(n_use, 16'h0002);
      check(n_log, 16'h0000);
      repeat (11) chk(1'b1, 1'b0, 1'b0);
      for (k = 0; k < 20; k++)
         rd(A_ERR_LO + 16'(k), 1'b0, eq[k]);
      check(n_log, 16'h000a);
      check({15'h0, val_stop}, 16'h0001);
      // First erase ends in failure, second in success
      for (k = 0; k < 2; k++)
      begin
         cc_master_model_i.erase_seq(5);
         @(posedge clk);
         check({15'h0, cc_master_model_i.got_exc}, 16'h0000);
         check(n_erase, 16'(k + 1));
         {done, ok} <= {1'b1, k == 1};
         @(posedge clk);
         {done, ok} <= 2'b00;
         repeat (2) @(posedge clk);
         check(n_dflt, 16'(k));
      end
      rd(A_SYS_STATE, 1'b0, SYS_NOT_CFG);
      rd(A_ERR_LO, 1'b0, ERR_RST);
      conclude();
   end
endmodule // tb
`default_nettype wire
